// ### dsod_brake_model.sv
// Behavioural lift brake controller watching two output terminals.
`timescale 1ns/100ps
module dsod_brake_model (
  // Clock, reset and watched terminals.
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_arrival,
  input wire logic i_torque,
  // Brake command.
  output logic o_braking
);
  // Brake start and stop.
  // Over-torque wins so the brake never holds against a loaded motor.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_braking <= 1'b0;
    end else if (i_torque) begin
      o_braking <= 1'b0;
    end else if (i_arrival) begin
      o_braking <= 1'b1;
    end
  end
endmodule

// ### dsod_chk.sv
// Concurrent checks of flag timing, hysteresis and terminal routing.
`timescale 1ns/100ps
module dsod_chk (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Drive state.
  input wire logic i_decelerating,
  input wire logic i_reverse,
  input wire logic i_regenerating,
  input wire logic [15:0] i_output_freq,
  input wire logic [15:0] i_motor_speed,
  input wire logic [15:0] i_max_freq,
  input wire logic [15:0] i_main_frequency_setting,
  input wire logic signed [9:0] i_est_torque,
  input wire logic [19:0] i_cumulative_run_time,
  input wire logic [19:0] i_cumulative_power_time,
  input wire logic [3:0] i_control_curve_select,
  // Detector settings.
  input wire logic [15:0] i_accel_arrival_thresh1,
  input wire logic [15:0] i_decel_arrival_thresh1,
  input wire logic [15:0] i_zero_speed_level,
  input wire logic [13:0] i_time_warning_setting,
  // Torque limits and terminal setup.
  input wire logic [7:0] i_torque_thresh_fwd_drive,
  input wire logic [7:0] i_torque_thresh_rev_regen,
  input wire logic [7:0] i_torque_thresh_rev_drive,
  input wire logic [7:0] i_torque_thresh_fwd_regen,
  input wire logic [39:0] i_output_terminal_function_sel,
  input wire logic [7:0] i_relay_function_sel,
  input wire logic [5:0] i_polarity_invert,
  // Observed outputs.
  input wire logic [4:0] o_terminal,
  input wire logic o_relay,
  input wire logic [8:0] o_flags
);
  // Hysteresis widths, frequency, target and threshold, widened against overflow.
  logic [17:0] hon, hoff, fq, tgt, thr;
  logic [23:0] lim;
  logic rnt_x, ont_x, zs_x, otq_x;
  logic [7:0] tq_thr;
  logic [9:0] tq_mag;
  logic [5:0] route;
  assign hon = 18'(i_max_freq) / 18'h64;
  assign hoff = 18'(i_max_freq) * 18'h2 / 18'h64;
  assign fq = 18'(i_output_freq);
  assign tgt = 18'(i_main_frequency_setting);
  assign thr = 18'(i_decelerating ? i_decel_arrival_thresh1 : i_accel_arrival_thresh1);
  // Small warning settings count tens of hours, large ones hundreds.
  assign lim = 24'(i_time_warning_setting) * ((i_time_warning_setting <= 14'h3E7) ? 24'hA : 24'h64);
  assign rnt_x = (i_time_warning_setting != 14'h0) && (24'(i_cumulative_run_time) > lim);
  assign ont_x = (i_time_warning_setting != 14'h0) && (24'(i_cumulative_power_time) > lim);
  assign zs_x = ((i_control_curve_select == 4'h5) ? i_motor_speed : i_output_freq) < i_zero_speed_level;
  assign tq_mag = i_est_torque[9] ? 10'(-i_est_torque) : 10'(i_est_torque);
  assign otq_x = tq_mag > 10'(tq_thr);
  // Quadrant picks the torque limit.
  always_comb begin
    case ({i_reverse, i_regenerating})
      2'b00: tq_thr = i_torque_thresh_fwd_drive;
      2'b01: tq_thr = i_torque_thresh_fwd_regen;
      2'b10: tq_thr = i_torque_thresh_rev_drive;
      default: tq_thr = i_torque_thresh_rev_regen;
    endcase
  end
  // Flag chosen by a function code; unknown codes give a low flag.
  function automatic logic pick(input logic [7:0] c, input logic [8:0] f);
    case (c)
      8'h01: pick = f[0];
      8'h02: pick = f[1];
      8'h06: pick = f[2];
      8'h18: pick = f[3];
      8'h19: pick = f[4];
      8'h0B: pick = f[5];
      8'h0C: pick = f[6];
      8'h15: pick = f[7];
      8'h07: pick = f[8];
      default: pick = 1'b0;
    endcase
  endfunction
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      route[k] = pick(i_output_terminal_function_sel[8*k+:8], o_flags) ^ i_polarity_invert[k];
    end
    route[5] = pick(i_relay_function_sel, o_flags) ^ i_polarity_invert[5];
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_const_on: assert property ((!o_flags[0] && fq + hon >= tgt) |=> o_flags[0])
    else $error("arrival flag did not rise");
  // The on level wins over the off level when a tiny maximum makes both bands empty.
  a_const_off: assert property ((o_flags[0] && fq + hoff <= tgt && fq + hon < tgt) |=> !o_flags[0])
    else $error("arrival flag did not fall");
  a_over_on: assert property ((thr != 18'h0 && fq + hon >= thr) |=> o_flags[1])
    else $error("overreach flag missing");
  a_arrive_off: assert property ((thr == 18'h0) |=> !o_flags[1] && !o_flags[2])
    else $error("disabled arrival flag set");
  a_exact_band: assert property (o_flags[2] |-> $past(fq) + hoff > $past(thr) && $past(fq) < $past(thr) + hoff)
    else $error("exact arrival outside band");
  a_zero_speed: assert property (1'b1 |=> o_flags[7] == $past(zs_x))
    else $error("zero speed flag wrong");
  a_run_time: assert property (1'b1 |=> o_flags[5] == $past(rnt_x))
    else $error("run time flag wrong");
  a_power_time: assert property (1'b1 |=> o_flags[6] == $past(ont_x))
    else $error("power time flag wrong");
  a_over_torque: assert property (1'b1 |=> o_flags[8] == $past(otq_x))
    else $error("over torque flag wrong");
  a_term_route: assert property (1'b1 |=> {o_relay, o_terminal} == $past(route))
    else $error("terminal routing wrong");
endmodule
bind dsod_top dsod_chk dsod_chk_inst (.*);

// ### dsod_pkg.sv
// Package with constants and types for the drive status output detectors.
package dsod_pkg;

  // Frequency values are in units of 0.01 Hz.
  localparam int FREQ_W = 16;
  // Torque values are in percent, signed for the estimate.
  localparam int TORQ_W = 10;
  // Cumulative times are in hours.
  localparam int TIME_W = 20;
  // Warning time setting width.
  localparam int WARN_W = 14;
  // Function selection code width.
  localparam int SEL_W = 8;
  // Number of open-collector terminals.
  localparam int NUM_TERM = 5;

  // Function selection codes.
  localparam logic [7:0] FN_CONST_SPEED = 8'h01;
  localparam logic [7:0] FN_OVERREACH1 = 8'h02;
  localparam logic [7:0] FN_EXACT1 = 8'h06;
  localparam logic [7:0] FN_OVER_TORQUE = 8'h07;
  localparam logic [7:0] FN_RUN_TIME = 8'h0B;
  localparam logic [7:0] FN_POWER_TIME = 8'h0C;
  localparam logic [7:0] FN_ZERO_SPEED = 8'h15;
  localparam logic [7:0] FN_OVERREACH2 = 8'h18;
  localparam logic [7:0] FN_EXACT2 = 8'h19;

  // Hysteresis in percent of maximum frequency.
  localparam int HYST_ON_PCT = 1;
  localparam int HYST_OFF_PCT = 2;

  // Warning time decode: 1..999 in tens of hours, 1000..6553 in hundreds.
  localparam int WARN_TEN_MAX = 999;
  localparam int WARN_UNIT_TEN = 10;
  localparam int WARN_UNIT_HUNDRED = 100;

  // Control curve codes that give vector control.
  localparam logic [3:0] CURVE_SLV = 4'h3;
  localparam logic [3:0] CURVE_ZERO_HZ_SLV = 4'h4;
  localparam logic [3:0] CURVE_SENSOR_VEC = 4'h5;

  // Reset value of every flag and terminal.
  localparam logic RST_FLAG = 1'b0;

endpackage

// ### dsod_top.sv
// Status flag detectors and output terminal routing for a motor drive.
//
// Functional notes
// - Flags routable to five terminals and relay.
// - Codes 01,02,24,06,25 select arrival flags.
// - Arrival on at target-1%, off at target-2%.
// - Exact arrival accel: on -1%, off +2%.
// - Exact arrival decel: on +1%, off -2%.
// - Constant speed compares with commanded frequency.
// - Overreach holds while frequency exceeds threshold.
// - Exact arrival only near threshold, hysteresis.
// - Zero threshold disables its arrival output.
// - Run time over warning sets code 11.
// - Power time over warning sets code 12.
// - Warning decode: zero off, 10h, 100h units.
// - Zero speed while monitored below level.
// - Zero speed level 0.00 to 100.0 Hz.
// - Sensor vector uses speed, else frequency.
// - Over torque when torque exceeds quadrant threshold.
// - Four quadrant thresholds, 0 to 180 percent.
// - Over torque meaningful only in vector modes.
// - Polarity 00 normal, 01 inverted per terminal.
`timescale 1ns/100ps
module dsod_top (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Drive state from the control core.
  input wire logic [15:0] i_output_freq,
  input wire logic [15:0] i_motor_speed,
  input wire logic [15:0] i_max_freq,
  input wire logic [15:0] i_main_frequency_setting,
  input wire logic i_accelerating,
  input wire logic i_decelerating,
  input wire logic i_reverse,
  input wire logic i_regenerating,
  input wire logic signed [9:0] i_est_torque,
  input wire logic [19:0] i_cumulative_run_time,
  input wire logic [19:0] i_cumulative_power_time,
  input wire logic [3:0] i_control_curve_select,
  // Configuration settings.
  input wire logic [15:0] i_accel_arrival_thresh1,
  input wire logic [15:0] i_decel_arrival_thresh1,
  input wire logic [15:0] i_accel_arrival_thresh2,
  input wire logic [15:0] i_decel_arrival_thresh2,
  input wire logic [13:0] i_time_warning_setting,
  input wire logic [15:0] i_zero_speed_level,
  input wire logic [7:0] i_torque_thresh_fwd_drive,
  input wire logic [7:0] i_torque_thresh_rev_regen,
  input wire logic [7:0] i_torque_thresh_rev_drive,
  input wire logic [7:0] i_torque_thresh_fwd_regen,
  input wire logic [39:0] i_output_terminal_function_sel,
  input wire logic [7:0] i_relay_function_sel,
  input wire logic [5:0] i_polarity_invert,
  // Terminal outputs and raw flags.
  output logic [4:0] o_terminal,
  output logic o_relay,
  output logic [8:0] o_flags
);

  //////////////////////////////////////////////////////////////////////////////
  // Flag registers.
  logic const_speed_arrival_r;  // Constant-speed arrival.
  logic overreach_pair1_r;  // Overreach of threshold pair one.
  logic exact_arrival_pair1_r;  // Exact arrival at pair one.
  logic overreach_pair2_r;  // Overreach of threshold pair two.
  logic exact_arrival_pair2_r;  // Exact arrival at pair two.
  logic run_time_over_r;  // Run time over warning.
  logic power_on_time_over_r;  // Power-on time over warning.
  logic zero_speed_flag_r;  // Zero speed detected.
  logic over_torque_flag_r;  // Over torque detected.
  logic [4:0] terminal_r;  // Registered terminal levels.
  logic relay_r;  // Registered relay level.

  // Hysteresis widths, computed from the maximum frequency.
  logic [17:0] hyst_on;
  logic [17:0] hyst_off;
  always_comb begin
    hyst_on = 18'((32'(i_max_freq) * dsod_pkg::HYST_ON_PCT) / 100);
    hyst_off = 18'((32'(i_max_freq) * dsod_pkg::HYST_OFF_PCT) / 100);
  end

  // Plain arrival hysteresis: on at or above target-on, off at or below target-off.
  function automatic logic arrive_next(input logic cur, input logic [15:0] f,
                                       input logic [15:0] tgt, input logic [17:0] hon,
                                       input logic [17:0] hoff);
    logic signed [18:0] fs;
    logic signed [18:0] on_lvl;
    logic signed [18:0] off_lvl;
    fs = 19'(f);
    on_lvl = 19'(tgt) - 19'(hon);
    off_lvl = 19'(tgt) - 19'(hoff);
    if (fs >= on_lvl) begin
      arrive_next = 1'b1;
    end else if (fs <= off_lvl) begin
      arrive_next = 1'b0;
    end else begin
      arrive_next = cur;
    end
  endfunction

  // Exact arrival: band around the threshold, direction-dependent edges.
  function automatic logic exact_next(input logic cur, input logic [15:0] f,
                                      input logic [15:0] tgt, input logic [17:0] hon,
                                      input logic [17:0] hoff, input logic decel);
    logic signed [18:0] fs;
    logic signed [18:0] t;
    logic signed [18:0] hn;
    logic signed [18:0] hf;
    // Signed copies keep a low threshold minus hysteresis negative, not wrapped.
    fs = 19'(f);
    t = 19'(tgt);
    hn = 19'(hon);
    hf = 19'(hoff);
    exact_next = cur;
    if (!decel) begin
      // Rising through: on at t-on, off at or above t+off.
      if (fs >= t + hf) begin
        exact_next = 1'b0;
      end else if (fs >= t - hn) begin
        exact_next = 1'b1;
      end else if (fs <= t - hf) begin
        exact_next = 1'b0;
      end
    end else begin
      // Falling through: on at t+on, off at or below t-off.
      if (fs <= t - hf) begin
        exact_next = 1'b0;
      end else if (fs <= t + hn) begin
        exact_next = 1'b1;
      end else if (fs >= t + hf) begin
        exact_next = 1'b0;
      end
    end
  endfunction

  // Warning time in hours; zero means disabled.
  function automatic logic [19:0] warn_hours(input logic [13:0] s);
    if (32'(s) <= dsod_pkg::WARN_TEN_MAX) begin
      warn_hours = 20'(32'(s) * dsod_pkg::WARN_UNIT_TEN);
    end else begin
      warn_hours = 20'(32'(s) * dsod_pkg::WARN_UNIT_HUNDRED);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Active threshold per pair follows the ramp direction.
  logic [15:0] thr1;
  logic [15:0] thr2;
  always_comb begin
    thr1 = i_decelerating ? i_decel_arrival_thresh1 : i_accel_arrival_thresh1;
    thr2 = i_decelerating ? i_decel_arrival_thresh2 : i_accel_arrival_thresh2;
  end

  // Constant-speed arrival against the commanded frequency.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      const_speed_arrival_r <= dsod_pkg::RST_FLAG;
    end else begin
      const_speed_arrival_r <= arrive_next(const_speed_arrival_r, i_output_freq,
                                           i_main_frequency_setting, hyst_on, hyst_off);
    end
  end

  // Overreach flags for both threshold pairs; zero threshold forces them off.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      overreach_pair1_r <= dsod_pkg::RST_FLAG;
      overreach_pair2_r <= dsod_pkg::RST_FLAG;
    end else begin
      overreach_pair1_r <= (thr1 != 16'h0000) &&
                           arrive_next(overreach_pair1_r, i_output_freq, thr1, hyst_on, hyst_off);
      overreach_pair2_r <= (thr2 != 16'h0000) &&
                           arrive_next(overreach_pair2_r, i_output_freq, thr2, hyst_on, hyst_off);
    end
  end

  // Exact arrival flags; direction picks which hysteresis edges apply.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      exact_arrival_pair1_r <= dsod_pkg::RST_FLAG;
      exact_arrival_pair2_r <= dsod_pkg::RST_FLAG;
    end else begin
      exact_arrival_pair1_r <= (thr1 != 16'h0000) &&
        exact_next(exact_arrival_pair1_r, i_output_freq, thr1, hyst_on, hyst_off, i_decelerating);
      exact_arrival_pair2_r <= (thr2 != 16'h0000) &&
        exact_next(exact_arrival_pair2_r, i_output_freq, thr2, hyst_on, hyst_off, i_decelerating);
    end
  end

  // Time warnings; the counters only grow so no hysteresis is needed.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      run_time_over_r <= dsod_pkg::RST_FLAG;
      power_on_time_over_r <= dsod_pkg::RST_FLAG;
    end else begin
      run_time_over_r <= (i_time_warning_setting != 14'h0000) &&
                         (i_cumulative_run_time > warn_hours(i_time_warning_setting));
      power_on_time_over_r <= (i_time_warning_setting != 14'h0000) &&
                              (i_cumulative_power_time > warn_hours(i_time_warning_setting));
    end
  end

  // Zero speed detection on the mode-selected source.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      zero_speed_flag_r <= dsod_pkg::RST_FLAG;
    end else begin
      zero_speed_flag_r <= ((i_control_curve_select == dsod_pkg::CURVE_SENSOR_VEC) ?
                            i_motor_speed : i_output_freq) < i_zero_speed_level;
    end
  end

  // Quadrant threshold selection for the torque compare.
  logic [7:0] torq_thr;
  always_comb begin
    unique case ({i_reverse, i_regenerating})
      2'b00: torq_thr = i_torque_thresh_fwd_drive;
      2'b01: torq_thr = i_torque_thresh_fwd_regen;
      2'b10: torq_thr = i_torque_thresh_rev_drive;
      2'b11: torq_thr = i_torque_thresh_rev_regen;
    endcase
  end

  // Over torque on torque magnitude; outside vector modes the value is
  // meaningless, so the compare still runs rather than adding gating.
  logic [9:0] torq_mag;
  always_comb begin
    torq_mag = i_est_torque[9] ? 10'(-i_est_torque) : 10'(i_est_torque);
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      over_torque_flag_r <= dsod_pkg::RST_FLAG;
    end else begin
      over_torque_flag_r <= torq_mag > {2'b00, torq_thr};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Map a selection code to its flag; unknown codes read false.
  function automatic logic sel_flag(input logic [7:0] code, input logic [8:0] f);
    unique case (code)
      dsod_pkg::FN_CONST_SPEED: sel_flag = f[0];
      dsod_pkg::FN_OVERREACH1: sel_flag = f[1];
      dsod_pkg::FN_EXACT1: sel_flag = f[2];
      dsod_pkg::FN_OVERREACH2: sel_flag = f[3];
      dsod_pkg::FN_EXACT2: sel_flag = f[4];
      dsod_pkg::FN_RUN_TIME: sel_flag = f[5];
      dsod_pkg::FN_POWER_TIME: sel_flag = f[6];
      dsod_pkg::FN_ZERO_SPEED: sel_flag = f[7];
      dsod_pkg::FN_OVER_TORQUE: sel_flag = f[8];
      default: sel_flag = 1'b0;
    endcase
  endfunction

  logic [8:0] flags;
  always_comb begin
    flags = {over_torque_flag_r, zero_speed_flag_r, power_on_time_over_r, run_time_over_r,
             exact_arrival_pair2_r, overreach_pair2_r, exact_arrival_pair1_r,
             overreach_pair1_r, const_speed_arrival_r};
  end

  // Terminal routing with polarity, one flip-flop per terminal.
  genvar gi;
  generate
    for (gi = 0; gi < dsod_pkg::NUM_TERM; gi++) begin : g_term
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          terminal_r[gi] <= dsod_pkg::RST_FLAG;
        end else begin
          terminal_r[gi] <= sel_flag(i_output_terminal_function_sel[gi*8 +: 8], flags) ^
                            i_polarity_invert[gi];
        end
      end
    end
  endgenerate

  // Relay routing with its own polarity.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      relay_r <= dsod_pkg::RST_FLAG;
    end else begin
      relay_r <= sel_flag(i_relay_function_sel, flags) ^ i_polarity_invert[5];
    end
  end

  assign o_terminal = terminal_r;
  assign o_relay = relay_r;
  assign o_flags = flags;

endmodule

// ### dsod_top_test.sv
// Self-checking bench for the drive status output detectors.
`timescale 1ns/100ps
module dsod_top_test;
  // Signals named as the design ports so they connect by name.
  logic i_clk, i_rst, i_accelerating, i_decelerating, i_reverse, i_regenerating, o_relay, braking;
  logic [15:0] i_output_freq, i_motor_speed, i_max_freq, i_main_frequency_setting, i_zero_speed_level;
  logic [15:0] i_accel_arrival_thresh1, i_decel_arrival_thresh1, i_accel_arrival_thresh2, i_decel_arrival_thresh2;
  logic signed [9:0] i_est_torque;
  logic [19:0] i_cumulative_run_time, i_cumulative_power_time;
  logic [3:0] i_control_curve_select;
  logic [13:0] i_time_warning_setting;
  logic [7:0] i_torque_thresh_fwd_drive, i_torque_thresh_rev_regen, i_relay_function_sel;
  logic [7:0] i_torque_thresh_rev_drive, i_torque_thresh_fwd_regen;
  logic [39:0] i_output_terminal_function_sel;
  logic [5:0] i_polarity_invert;
  logic [4:0] o_terminal;
  logic [8:0] o_flags;
  int fails, n_compared;
  dsod_top dsod_top_inst (.*);
  dsod_brake_model dsod_brake_model_inst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_arrival(o_terminal[0]),
    .i_torque(o_terminal[1]),
    .o_braking(braking)
  );
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // Three edges cover flag, terminal and the brake model behind it.
  task automatic settle();
    repeat (3) @(negedge i_clk);
  endtask
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Arrival edges at both hysteresis limits, normal terminal and inverted relay.
  task automatic t_const();
    logic [15:0] f[4] = '{16'h16F7, 16'h16F8, 16'h1681, 16'h1680};
    logic [3:0] e = 4'b0110;
    for (int k = 0; k < 4; k++) begin
      i_output_freq = f[k];
      settle();
      chk(o_flags[0], e[k]);
      chk({o_relay, o_terminal[0]}, {~e[k], e[k]});
    end
  endtask
  // Every function code on all outputs, one unknown code last.
  task automatic t_codes();
    logic [7:0] c[10] = '{8'h01, 8'h02, 8'h06, 8'h18, 8'h19, 8'h0B, 8'h0C, 8'h15, 8'h07, 8'h03};
    logic [9:0] e = 10'h03B;
    i_output_freq = 16'h16F8;
    i_accel_arrival_thresh1 = 16'h1388;
    i_accel_arrival_thresh2 = 16'h170C;
    i_time_warning_setting = 14'h1;
    {i_cumulative_run_time, i_cumulative_power_time} = {20'hB, 20'hA};
    settle();
    chk(o_flags, 9'h03B);
    chk(braking, 1'b1);
    for (int k = 0; k < 10; k++) begin
      i_output_terminal_function_sel = {5{c[k]}};
      i_relay_function_sel = c[k];
      settle();
      chk({o_relay, o_terminal}, {~e[k], {5{e[k]}}});
    end
    i_output_terminal_function_sel = 40'h0303030701;
    i_relay_function_sel = 8'h01;
  endtask
  // Warning time in both units at the boundary, then switched off.
  task automatic t_time();
    logic [13:0] s[3] = '{14'h3E8, 14'h3E7, 14'h0};
    logic [19:0] r[3] = '{20'h186A1, 20'h2706, 20'hFFFFF};
    logic [19:0] p[3] = '{20'h186A0, 20'h2707, 20'hFFFFF};
    logic [1:0] e[3] = '{2'b01, 2'b10, 2'b00};
    for (int k = 0; k < 3; k++) begin
      i_time_warning_setting = s[k];
      {i_cumulative_run_time, i_cumulative_power_time} = {r[k], p[k]};
      settle();
      chk(o_flags[6:5], e[k]);
    end
  endtask
  // Zero speed watches speed only under sensor vector control.
  task automatic t_zero();
    i_zero_speed_level = 16'h64;
    for (int k = 0; k < 4; k++) begin
      i_control_curve_select = k[1] ? 4'h5 : 4'h1;
      i_output_freq = k[0] ? 16'h64 : 16'h63;
      i_motor_speed = k[0] ? 16'h63 : 16'h64;
      settle();
      chk(o_flags[7], (k[1] == k[0]));
    end
  endtask
  // Each quadrant at its own limit, then just past it with negative torque.
  task automatic t_torque();
    logic [9:0] t[4] = '{10'hA, 10'h28, 10'h1E, 10'h14};
    {i_torque_thresh_fwd_drive, i_torque_thresh_rev_regen} = 16'h0A14;
    {i_torque_thresh_rev_drive, i_torque_thresh_fwd_regen} = 16'h1E28;
    // The brake still holds from the earlier arrival while torque is low.
    chk(braking, 1'b1);
    for (int k = 0; k < 4; k++) begin
      {i_reverse, i_regenerating} = k[1:0];
      i_est_torque = t[k];
      settle();
      chk(o_flags[8], 1'b0);
      i_est_torque = -(t[k] + 10'h1);
      settle();
      chk(o_flags[8], 1'b1);
    end
    {i_reverse, i_regenerating} = 2'b00;
    i_torque_thresh_fwd_drive = 8'hB4;
    i_est_torque = 10'hB5;
    settle();
    chk({braking, o_flags[8]}, 2'b01);
  endtask
  // Exact and overreach flags through accel and decel edges, then disabled.
  task automatic t_exact();
    logic [15:0] f[9] = '{16'h130F, 16'h1310, 16'h1477, 16'h1478, 16'h1401, 16'h1400, 16'h1299, 16'h1298, 16'h1388};
    logic [8:0] d = 9'h0F0;
    logic [8:0] ov = 9'h07E;
    logic [8:0] ex = 9'h066;
    for (int k = 0; k < 9; k++) begin
      {i_decelerating, i_accelerating} = {d[k], !d[k]};
      i_output_freq = f[k];
      {i_accel_arrival_thresh1, i_decel_arrival_thresh1} = {2{k == 8 ? 16'h0 : 16'h1388}};
      {i_accel_arrival_thresh2, i_decel_arrival_thresh2} = {2{k == 8 ? 16'h0 : 16'h1388}};
      settle();
      chk(o_flags[2:1], {ex[k], ov[k]});
      chk(o_flags[4:3], {ex[k], ov[k]});
    end
  endtask
  // Outputs stay low in reset even when inverted, then come back.
  task automatic t_reset();
    i_polarity_invert = 6'h3F;
    i_rst = 1'b1;
    @(negedge i_clk);
    chk({o_relay, o_terminal, o_flags}, 15'h0);
    i_rst = 1'b0;
    settle();
    chk({o_relay, o_terminal[4:2]}, 4'hF);
  endtask
  initial begin
    {fails, n_compared} = 64'h0;
    i_rst = 1'b1;
    {i_accelerating, i_decelerating, i_reverse, i_regenerating} = 4'h8;
    {i_output_freq, i_motor_speed, i_est_torque, i_zero_speed_level} = 58'h0;
    {i_max_freq, i_main_frequency_setting} = {16'h2EE0, 16'h1770};
    {i_accel_arrival_thresh1, i_decel_arrival_thresh1, i_accel_arrival_thresh2, i_decel_arrival_thresh2} = 64'h0;
    {i_cumulative_run_time, i_cumulative_power_time, i_time_warning_setting} = 54'h0;
    i_control_curve_select = 4'h1;
    {i_torque_thresh_fwd_drive, i_torque_thresh_rev_regen} = 16'hB4B4;
    {i_torque_thresh_rev_drive, i_torque_thresh_fwd_regen} = 16'hB4B4;
    i_output_terminal_function_sel = 40'h0303030701;
    {i_relay_function_sel, i_polarity_invert} = {8'h01, 6'h20};
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    t_const();
    t_codes();
    t_time();
    t_zero();
    t_torque();
    t_exact();
    t_reset();
    report_and_stop();
  end
endmodule
